// File: rtl/trace_capture_defines.vh
`ifndef TRACE_CAPTURE_DEFINES_VH
`define TRACE_CAPTURE_DEFINES_VH

// ----------------------------------------
// Record layout
// ----------------------------------------
`define TAG_W 4
`define PAY_W 32
`define REC_W 36

// ----------------------------------------
// Record tags
// ----------------------------------------
`define TAG_RESUME 4'h1
`define TAG_TRIGGER 4'h2
`define TAG_PC_SERIAL 4'h3
`define TAG_BUS_BEAT 4'h4
`define TAG_LA_SAMPLE 4'h5
`define TAG_CORE_STATUS 4'h6

// ----------------------------------------
// Pin widths and sync vector positions
// ----------------------------------------
`define TD_W 8
`define TS_W 5
`define DS_W 3
`define BTS_W 5
`define SYNC_W 24
`define SY_SER 23
`define SY_TD_HI 22
`define SY_TD_LO 15
`define SY_TS_HI 14
`define SY_TS_LO 10
`define SY_XT 9
`define SY_DS_HI 8
`define SY_DS_LO 6
`define SY_PC 5
`define SY_BTS_HI 4
`define SY_BTS_LO 0
`define BTS_START 4

// ----------------------------------------
// Timing counts, in target core clock cycles, and payload alignment shifts in bits
// ----------------------------------------
`define PC_CYC_SHORT 5'h1b
`define PC_CYC_LONG 5'h1f
`define BUS_BEATS_MAX 3'h7
`define CNT5_ONE 5'h01
`define CNT5_ZERO 5'h00
`define IDX_ZERO 3'h0
`define IDX_ONE 3'h1
`define PC_ALIGN_LONG 2
`define PC_ALIGN_SHORT 6

// ----------------------------------------
// Reset values
// ----------------------------------------
// Serial line and PC line idle high, so their sync stages reset high to avoid a false start
`define RST_SYNC 24'h80_0020
`define RST_PAY 32'h0000_0000
`define RST_REC 36'h0_0000_0000

`endif

// File: rtl/record_fifo.v
module record_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // Drain side
  input wire out_ready,
  output reg out_valid_q,
  output reg [WIDTH-1:0] out_data_q
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;
  wire [AW:0] depth_c;

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  assign depth_c = DEPTH[AW:0];
  assign in_ready = (count_q != depth_c);
  assign push = in_valid && in_ready;
  // Output stage refills only when empty or drained, so a stalled sink really fills the array
  assign pop = (count_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready);

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
        out_data_q <= mem[rd_ptr_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // record_fifo

// File: rtl/trace_capture_port.v
// Operation
// - Break request drives debug serial line low; released line idles high by pull-up.
// - Logic-analyzer mode samples 17 target signals (14 trace lines plus 3 debug status lines) in each cycle with no resume, trigger, PC or bus beat record.
// - Record resume PC, trigger address and each serial PC as reference points.
// - Item mask restricts which bus trace items are captured and kept.
`include "trace_capture_defines.vh"

module trace_capture_port #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4,
  parameter LA_W = 14
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Probe control
  input wire break_req,
  input wire la_mode,
  input wire pc_trace_en,
  input wire bus_trace_en,
  input wire pc_len_long,
  input wire [7:0] bus_item_mask,
  input wire resume_pulse,
  input wire [`PAY_W-1:0] resume_pc,
  input wire trigger_pulse,
  input wire [`PAY_W-1:0] trigger_addr,
  // Debug serial line, open drain
  input wire debug_serial_line_in,
  output reg debug_serial_line_out_q,
  output reg debug_serial_line_oe_n_q,
  // Trace pins from the target
  input wire [`TD_W-1:0] trace_data_lines,
  input wire [`TS_W-1:0] trace_status_lines,
  input wire extra_trace_line,
  input wire [`DS_W-1:0] debug_status_lines,
  input wire debug_pc_serial_out,
  input wire [`BTS_W-1:0] bus_trace_status_lines,
  // Record stream
  input wire rec_ready,
  output wire rec_valid,
  output wire [`REC_W-1:0] rec_data,
  // Status
  output reg overflow_q,
  output reg serial_line_low_q
);

  // ----------------------------------------
  // Record packing
  // ----------------------------------------
  function [`REC_W-1:0] make_rec;
    input [`TAG_W-1:0] tag;
    input [`PAY_W-1:0] pay;
    begin
      make_rec = {tag, pay};
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [`SYNC_W-1:0] sync1_q;
  reg [`SYNC_W-1:0] sync2_q;
  wire [`SYNC_W-1:0] pins_raw;

  assign pins_raw = {debug_serial_line_in, trace_data_lines, trace_status_lines,
                     extra_trace_line, debug_status_lines, debug_pc_serial_out,
                     bus_trace_status_lines};

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= `RST_SYNC;
      sync2_q <= `RST_SYNC;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire [`TD_W-1:0] td_s;
  wire [`TS_W-1:0] ts_s;
  wire xt_s;
  wire [`DS_W-1:0] ds_s;
  wire pc_s;
  wire [`BTS_W-1:0] bts_s;
  wire [LA_W-1:0] la_s;

  assign td_s = sync2_q[`SY_TD_HI:`SY_TD_LO];
  assign ts_s = sync2_q[`SY_TS_HI:`SY_TS_LO];
  assign xt_s = sync2_q[`SY_XT];
  assign ds_s = sync2_q[`SY_DS_HI:`SY_DS_LO];
  assign pc_s = sync2_q[`SY_PC];
  assign bts_s = sync2_q[`SY_BTS_HI:`SY_BTS_LO];
  assign la_s = {td_s, ts_s, xt_s};

  // ----------------------------------------
  // Forced break drive
  // ----------------------------------------
  // The line is only ever pulled low; high comes from the target pull-up
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_serial_line_out_q <= 1'b0;
      debug_serial_line_oe_n_q <= 1'b1;
      serial_line_low_q <= 1'b0;
    end else begin
      debug_serial_line_out_q <= 1'b0;
      debug_serial_line_oe_n_q <= ~break_req;
      serial_line_low_q <= ~sync2_q[`SY_SER];
    end
  end

  // ----------------------------------------
  // Serial PC receiver
  // ----------------------------------------
  localparam PC_IDLE = 1'b0;
  localparam PC_SHIFT = 1'b1;

  reg pc_state_q;
  reg [4:0] pc_left_q;
  reg [`PAY_W-1:0] pc_shift_q;
  reg pc_done_q;
  reg [`PAY_W-1:0] pc_value_q;
  wire [4:0] pc_len;

  // A start cycle plus payload; long frames carry four more bits
  assign pc_len = pc_len_long ? `PC_CYC_LONG : `PC_CYC_SHORT;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_state_q <= PC_IDLE;
      pc_left_q <= `CNT5_ZERO;
      pc_shift_q <= `RST_PAY;
      pc_done_q <= 1'b0;
      pc_value_q <= `RST_PAY;
    end else begin
      pc_done_q <= 1'b0;
      case (pc_state_q)
        PC_IDLE: begin
          if (pc_trace_en && !pc_s) begin
            pc_state_q <= PC_SHIFT;
            pc_left_q <= pc_len - `CNT5_ONE;
            pc_shift_q <= `RST_PAY;
          end
        end
        PC_SHIFT: begin
          pc_shift_q <= {pc_s, pc_shift_q[`PAY_W-1:1]};
          pc_left_q <= pc_left_q - `CNT5_ONE;
          if (pc_left_q == `CNT5_ONE) begin
            pc_state_q <= PC_IDLE;
            pc_done_q <= 1'b1;
            // Align LSB-first payload to bit 0
            pc_value_q <= pc_len_long ? {pc_s, pc_shift_q[`PAY_W-1:1]} >> `PC_ALIGN_LONG
                                      : {pc_s, pc_shift_q[`PAY_W-1:1]} >> `PC_ALIGN_SHORT;
          end
        end
        default: begin
          pc_state_q <= PC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Bus trace beat tracking
  // ----------------------------------------
  reg [2:0] bt_idx_q;
  reg bt_active_q;
  wire bt_start;
  wire [2:0] bt_idx_c;
  wire bt_keep;

  assign bt_start = bts_s[`BTS_START];
  // A start marker mid-record restarts the count; beats already kept from the partial record stay buffered
  assign bt_idx_c = bt_start ? `IDX_ZERO : bt_idx_q + `IDX_ONE;
  // Beats beyond the eighth are not part of any record
  assign bt_keep = bus_trace_en && (bt_start || (bt_active_q && bt_idx_q != `BUS_BEATS_MAX))
                   && bus_item_mask[bt_idx_c];

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bt_idx_q <= `IDX_ZERO;
      bt_active_q <= 1'b0;
    end else if (!bus_trace_en) begin
      bt_active_q <= 1'b0;
      bt_idx_q <= `IDX_ZERO;
    end else if (bt_start) begin
      bt_active_q <= 1'b1;
      bt_idx_q <= `IDX_ZERO;
    end else if (bt_active_q) begin
      if (bt_idx_q == `BUS_BEATS_MAX) begin
        bt_active_q <= 1'b0;
      end else begin
        bt_idx_q <= bt_idx_q + `IDX_ONE;
      end
    end
  end

  // ----------------------------------------
  // Core status change detect
  // ----------------------------------------
  reg [`DS_W-1:0] ds_prev_q;
  wire ds_change;

  assign ds_change = pc_trace_en && (ds_s != ds_prev_q);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ds_prev_q <= {`DS_W{1'b0}};
    end else begin
      ds_prev_q <= ds_s;
    end
  end

  // ----------------------------------------
  // Record selection
  // ----------------------------------------
  // One record per cycle; lower-priority events in the same cycle count as lost
  reg wr_valid;
  reg [`REC_W-1:0] wr_data;
  reg lost;
  wire fifo_ready;
  wire [3:0] ev_cnt;

  assign ev_cnt = {3'h0, resume_pulse} + {3'h0, trigger_pulse} + {3'h0, pc_done_q}
                + {3'h0, bt_keep} + {3'h0, la_mode} + {3'h0, ds_change};

  always @* begin
    wr_valid = 1'b1;
    wr_data = `RST_REC;
    if (resume_pulse) begin
      wr_data = make_rec(`TAG_RESUME, resume_pc);
    end else if (trigger_pulse) begin
      wr_data = make_rec(`TAG_TRIGGER, trigger_addr);
    end else if (pc_done_q) begin
      wr_data = make_rec(`TAG_PC_SERIAL, pc_value_q);
    end else if (bt_keep) begin
      wr_data = make_rec(`TAG_BUS_BEAT, {16'h0000, bt_idx_c, ts_s, td_s});
    end else if (la_mode) begin
      wr_data = make_rec(`TAG_LA_SAMPLE, {15'h0000, ds_s, la_s});
    end else if (ds_change) begin
      wr_data = make_rec(`TAG_CORE_STATUS, {29'h0000_0000, ds_s});
    end else begin
      wr_valid = 1'b0;
    end
    lost = (ev_cnt > 4'h1) || (wr_valid && !fifo_ready);
  end

  // Capture never holds back the target; a full buffer drops and flags instead
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_q <= 1'b0;
    end else if (lost) begin
      overflow_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Record buffer
  // ----------------------------------------
  record_fifo #(
    .WIDTH(`REC_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_data(wr_data),
    .in_ready(fifo_ready),
    .out_ready(rec_ready),
    .out_valid_q(rec_valid),
    .out_data_q(rec_data)
  );

endmodule // trace_capture_port

// File: verification/trace_capture_properties.sv
`include "trace_capture_defines.vh"
module trace_capture_checker (
  // Clock and reset
  input logic sys_clk,
  input logic rst_n,
  // Probe control
  input logic break_req,
  input logic la_mode,
  input logic resume_pulse,
  input logic trigger_pulse,
  // Debug serial line
  input logic debug_serial_line_in,
  input logic debug_serial_line_out_q,
  input logic debug_serial_line_oe_n_q,
  input logic serial_line_low_q,
  // Record stream
  input logic rec_ready,
  input logic rec_valid,
  input logic [`REC_W-1:0] rec_data,
  input logic overflow_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_break_drives_low: assert property (break_req |=> !debug_serial_line_oe_n_q)
    else $error("serial line not driven during break");
  a_break_releases: assert property (!break_req |=> debug_serial_line_oe_n_q)
    else $error("serial line driven without break");
  a_drive_level_low: assert property (debug_serial_line_out_q == 1'b0)
    else $error("serial line driven high");
  // Four samples cover the two sync stages plus the status register
  a_line_seen_low: assert property (!debug_serial_line_in [*4] |-> serial_line_low_q)
    else $error("low serial line not reported");
  a_line_seen_high: assert property (debug_serial_line_in [*4] |-> !serial_line_low_q)
    else $error("high serial line reported low");
  a_resume_recorded: assert property (resume_pulse |-> ##[1:3] rec_valid)
    else $error("resume record missing");
  a_trigger_recorded: assert property (trigger_pulse |-> ##[1:3] rec_valid)
    else $error("trigger record missing");
  // One edge to push, one to load the output stage
  a_sample_recorded: assert property (la_mode |-> ##2 rec_valid)
    else $error("analyzer sample record missing");
  a_record_holds: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
    else $error("record changed before taken");
  a_loss_sticky: assert property (overflow_q |=> overflow_q)
    else $error("loss flag cleared");
  cover property (rec_valid && rec_ready && rec_data[35:32] == `TAG_PC_SERIAL);
  cover property (rec_valid && rec_ready && rec_data[35:32] == `TAG_BUS_BEAT);
  cover property ($rose(overflow_q));
endmodule // trace_capture_checker

bind trace_capture_port trace_capture_checker trace_capture_checker_i (.*);

// File: verification/target_model.sv
module target_model (
  // Clock
  input logic sys_clk,
  // Debug serial line, open drain with pull-up
  input logic debug_serial_line_out_q,
  input logic debug_serial_line_oe_n_q,
  output logic debug_serial_line_in,
  // Trace pins
  output logic [7:0] trace_data_lines,
  output logic [4:0] trace_status_lines,
  output logic extra_trace_line,
  output logic [2:0] debug_status_lines,
  output logic debug_pc_serial_out,
  output logic [4:0] bus_trace_status_lines
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-up wins whenever the probe lets go of the line
  assign debug_serial_line_in = debug_serial_line_oe_n_q ? 1'b1 : debug_serial_line_out_q;
  initial begin
    trace_data_lines = 8'h00;
    trace_status_lines = 5'h00;
    extra_trace_line = 1'b0;
    debug_status_lines = 3'h0;
    debug_pc_serial_out = 1'b1;
    bus_trace_status_lines = 5'h00;
  end
  task automatic set_pins(input logic [7:0] td, input logic [4:0] ts, input logic xt,
                          input logic [2:0] ds);
    trace_data_lines = td;
    trace_status_lines = ts;
    extra_trace_line = xt;
    debug_status_lines = ds;
  endtask
  // Never waits on the probe: a target cannot be stalled by its trace
  task automatic send_pc(input logic [29:0] v, input logic long);
    int i;
    @(posedge sys_clk);
    #1;
    debug_pc_serial_out = 1'b0;
    for (i = 0; i < (long ? 30 : 26); i++) begin
      @(posedge sys_clk);
      #1;
      debug_pc_serial_out = v[i];
    end
    @(posedge sys_clk);
    #1;
    debug_pc_serial_out = 1'b1;
  endtask
  // Compressed records need fewer beats, so more of them survive a busy bus
  task automatic bus_burst(input logic compress);
    int k;
    for (k = 0; k < (compress ? 2 : 6); k++) begin
      @(posedge sys_clk);
      #1;
      bus_trace_status_lines = (k == 0 || k == 2) ? 5'h10 : 5'h00;
      trace_status_lines = 5'h0a;
      trace_data_lines = 8'h10 + k[7:0];
    end
    @(posedge sys_clk);
    #1;
    bus_trace_status_lines = 5'h00;
    trace_data_lines = 8'h00;
  endtask
endmodule // target_model

// File: verification/tb.sv
`include "trace_capture_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_n, break_req, la_mode, pc_trace_en, bus_trace_en, pc_len_long;
  logic resume_pulse, trigger_pulse, rec_ready, rec_valid, overflow_q, serial_line_low_q;
  logic debug_serial_line_in, debug_serial_line_out_q, debug_serial_line_oe_n_q;
  logic extra_trace_line, debug_pc_serial_out;
  logic [7:0] bus_item_mask, trace_data_lines;
  logic [4:0] trace_status_lines, bus_trace_status_lines;
  logic [2:0] debug_status_lines;
  logic [31:0] resume_pc, trigger_addr;
  logic [`REC_W-1:0] rec_data;
  logic [`REC_W-1:0] got [$];
  int num_errors = 0;
  int checks = 0;
  trace_capture_port trace_capture_port_i (.*);
  target_model target_model_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (rec_valid && rec_ready) got.push_back(rec_data);
  task automatic wrap_up();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [`REC_W-1:0] g, input logic [`REC_W-1:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic exp_rec(input logic [3:0] tag, input logic [31:0] pay);
    int i;
    for (i = 0; i < 80 && got.size() == 0; i++) cyc(1);
    if (got.size() == 0) begin
      num_errors++;
      wrap_up();
    end else begin
      chk(got.pop_front(), {tag, pay});
    end
  endtask
  task automatic test_break();
    break_req = 1'b1;
    cyc(1);
    chk(debug_serial_line_oe_n_q, 1'b0);
    cyc(4);
    chk(serial_line_low_q, 1'b1);
    break_req = 1'b0;
    cyc(6);
    chk(debug_serial_line_in, 1'b1);
    chk(serial_line_low_q, 1'b0);
  endtask
  task automatic test_ref();
    resume_pc = 32'h1234_5678;
    resume_pulse = 1'b1;
    cyc(1);
    resume_pulse = 1'b0;
    trigger_addr = 32'h00c0_ffee;
    trigger_pulse = 1'b1;
    cyc(1);
    trigger_pulse = 1'b0;
    exp_rec(`TAG_RESUME, 32'h1234_5678);
    exp_rec(`TAG_TRIGGER, 32'h00c0_ffee);
  endtask
  task automatic test_pc();
    pc_trace_en = 1'b1;
    target_model_i.set_pins(8'h00, 5'h00, 1'b0, 3'h5);
    exp_rec(`TAG_CORE_STATUS, 32'h0000_0005);
    target_model_i.send_pc(30'h02ab_cdef, 1'b0);
    exp_rec(`TAG_PC_SERIAL, 32'h02ab_cdef);
    pc_len_long = 1'b1;
    target_model_i.send_pc(30'h3abc_1235, 1'b1);
    exp_rec(`TAG_PC_SERIAL, 32'h3abc_1235);
    pc_trace_en = 1'b0;
  endtask
  task automatic test_la();
    target_model_i.set_pins(8'h5a, 5'h13, 1'b1, 3'h2);
    cyc(4);
    la_mode = 1'b1;
    cyc(1);
    la_mode = 1'b0;
    exp_rec(`TAG_LA_SAMPLE, {15'h0000, 3'h2, 8'h5a, 5'h13, 1'b1});
  endtask
  task automatic test_bus();
    bus_item_mask = 8'h05;
    bus_trace_en = 1'b1;
    target_model_i.bus_burst(1'b0);
    exp_rec(`TAG_BUS_BEAT, {16'h0000, 3'h0, 5'h0a, 8'h10});
    exp_rec(`TAG_BUS_BEAT, {16'h0000, 3'h0, 5'h0a, 8'h12});
    exp_rec(`TAG_BUS_BEAT, {16'h0000, 3'h2, 5'h0a, 8'h14});
    cyc(12);
    chk(got.size(), 0);
    bus_item_mask = 8'h03;
    target_model_i.bus_burst(1'b1);
    exp_rec(`TAG_BUS_BEAT, {16'h0000, 3'h0, 5'h0a, 8'h10});
    exp_rec(`TAG_BUS_BEAT, {16'h0000, 3'h1, 5'h0a, 8'h11});
    cyc(12);
    chk(got.size(), 0);
    bus_trace_en = 1'b0;
  endtask
  // Loss flag is sticky until reset, so this must run last
  task automatic test_fill();
    rec_ready = 1'b0;
    la_mode = 1'b1;
    cyc(10);
    chk(overflow_q, 1'b0);
    cyc(10);
    la_mode = 1'b0;
    cyc(2);
    chk(overflow_q, 1'b1);
    rec_ready = 1'b1;
    cyc(25);
    chk(got.size(), 17);
    chk(rec_valid, 1'b0);
  endtask
  initial begin
    {rst_n, break_req, la_mode, pc_trace_en, bus_trace_en, pc_len_long} = 6'h00;
    {resume_pulse, trigger_pulse} = 2'h0;
    resume_pc = 32'h0000_0000;
    trigger_addr = 32'h0000_0000;
    bus_item_mask = 8'hff;
    rec_ready = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    // Reset only here, never while the target is halted
    rst_n = 1'b1;
    chk(debug_serial_line_oe_n_q, 1'b1);
    chk(rec_valid, 1'b0);
    test_break();
    test_ref();
    test_pc();
    test_la();
    test_bus();
    test_fill();
    wrap_up();
  end
endmodule // tb
